// ===== verilog/ssa_switch_ctrl.sv
// control front end of an eight-switch array: serial shift register on the
// link clock, holding register and switch drive on the system clock
// assumes link_clk, serial_din and shift_en come from the host controller and
// that master_clear_n and latch_load are asynchronous pins
`timescale 1ns/1ns

// Function
// [RULE1] Each link clock pulse with shifting active moves the serial input bit into the shift register.
// [RULE2] While the load input is active the holding register copies the shift register and keeps it after.
// [RULE3] Each holding register bit drives its own switch so any combination may be closed at once.
// [RULE4] Driving the active-low master clear empties the shift register and the holding register.
// [RULE5] The bit leaving the last shift stage appears on the serial output for chaining arrays.
// [RULE6] Shift and load act on the level of their inputs and hold state while inactive.
// [RULE7] A one in a holding bit closes its switch and a zero opens it.
module ssa_switch_ctrl
  import ssa_pkg::*;
#(
  parameter int NUM_SWITCH = SSA_NUM_SWITCH
)
(
  // system clock domain
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // control pins, asynchronous to clk
  input  wire logic                  master_clear_n,
  input  wire logic                  latch_load,
  // serial link from the host, on its own clock
  input  wire logic                  link_clk,
  input  wire logic                  shift_en,
  input  wire logic                  serial_din,
  output logic                       serial_dout,
  // switch drive, one bit per switch, high closes it
  output logic [NUM_SWITCH-1:0]      switch_on
);

  // link domain state
  logic [NUM_SWITCH-1:0] shift_reg;
  logic                  xfer_toggle;
  logic                  shift_prev;
  logic [1:0]            link_ctl;
  logic                  link_rst;
  logic                  link_clr;

  // system domain state
  logic [2:0]            sys_ctl;
  logic                  clr_s;
  logic                  load_s;
  logic                  tog_s;
  logic                  tog_d;
  logic                  capture;
  logic [NUM_SWITCH-1:0] mirror;
  logic [NUM_SWITCH-1:0] holding;

  // reset and clear reach the link domain through their own synchroniser
  ssa_sync #(
    .WIDTH (2)
  ) u_link_sync (
    .clk  (link_clk),
    .din  ({rst, ~master_clear_n}),
    .dout (link_ctl)
  );

  assign link_rst = link_ctl[1];
  assign link_clr = link_ctl[0];

  // shift register: one stage move per link edge while shift_en is high
  always_ff @(posedge link_clk)
  begin
    if (link_rst || link_clr)
    begin
      shift_reg <= NUM_SWITCH'(SSA_CLEAR_VALUE); // [RULE4]
    end
    else if (shift_en) // [RULE6]
    begin
      shift_reg <= {shift_reg[NUM_SWITCH-2:0], serial_din}; // [RULE1]
    end
  end

  // chaining output, last stage leaves on the same edge the next one fills
  always_ff @(posedge link_clk)
  begin
    if (link_rst || link_clr)
    begin
      serial_dout <= SSA_BIT_LOW; // [RULE4]
    end
    else if (shift_en)
    begin
      serial_dout <= shift_reg[NUM_SWITCH-1]; // [RULE5]
    end
  end

  // run flag: remembers whether the previous link edge shifted
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      shift_prev <= SSA_BIT_LOW;
    end
    else
    begin
      shift_prev <= shift_en;
    end
  end

  // event flag for the other domain, flips once on the first quiet edge
  // after a run; flips stay two link periods apart, so clk sees each one
  // as long as two link periods exceed one clk period
  // limitation: a frame whose clock stops with shift_en high is not signalled
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      xfer_toggle <= SSA_BIT_LOW;
    end
    else if (shift_prev && !shift_en)
    begin
      xfer_toggle <= ~xfer_toggle;
    end
  end

  // pins and the toggle enter the system domain
  ssa_sync #(
    .WIDTH (3)
  ) u_sys_sync (
    .clk  (clk),
    .din  ({~master_clear_n, latch_load, xfer_toggle}),
    .dout (sys_ctl)
  );

  assign clr_s  = sys_ctl[2];
  assign load_s = sys_ctl[1];
  assign tog_s  = sys_ctl[0];

  // edge detect on the synchronised toggle only, never on the first stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tog_d <= SSA_BIT_LOW;
    end
    else if (ce)
    begin
      tog_d <= tog_s;
    end
  end

  assign capture = tog_s ^ tog_d;

  // mirror of the shift register; word is quiet once its toggle has
  // crossed; a capture that meets a new run may be transient, but that
  // run's own end flips the toggle again and recaptures the final word
  always_ff @(posedge clk)
  begin
    if (rst || (ce && clr_s))
    begin
      mirror <= NUM_SWITCH'(SSA_CLEAR_VALUE); // [RULE4]
    end
    else if (ce && capture)
    begin
      mirror <= shift_reg;
    end
  end

  // holding register: follows the mirror while load is high, else holds
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      holding <= NUM_SWITCH'(SSA_CLEAR_VALUE);
    end
    else if (ce)
    begin
      if (clr_s)
      begin
        holding <= NUM_SWITCH'(SSA_CLEAR_VALUE); // [RULE4]
      end
      else if (load_s) // [RULE6]
      begin
        holding <= mirror; // [RULE2]
      end
    end
  end

  // one switch per bit, high closes it; no decoding so any mix is legal
  assign switch_on = holding; // [RULE3] [RULE7]

  // checks in the system domain
  default clocking cb_sys @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_load_req;
    ce && load_s && !clr_s;
  endsequence

  sequence seq_idle;
    ce && !load_s && !clr_s;
  endsequence

  sequence seq_clear_req;
    ce && clr_s;
  endsequence

  a_load_copies_mirror: assert property ( // [RULE2]
    seq_load_req |=> holding == $past(mirror))
    else $error("holding register did not copy the shift word on load");

  a_hold_when_idle: assert property ( // [RULE6]
    seq_idle |=> $stable(holding))
    else $error("holding register changed without load or clear");

  a_clear_empties: assert property ( // [RULE4]
    seq_clear_req |=> (holding == '0) && (mirror == '0))
    else $error("master clear left a latch set");

  a_switch_follow: assert property ( // [RULE6]
    $changed(switch_on) |-> $past(load_s || clr_s) && $past(ce))
    else $error("switch drive changed without load or clear");

  a_switch_indep: assert property ( // [RULE3]
    seq_load_req ##1 seq_load_req |=> switch_on == $past(mirror))
    else $error("switch drive does not match the loaded pattern bit for bit");

  a_freeze_on_ce: assert property (
    !ce |=> $stable(holding) && $stable(mirror))
    else $error("state moved while clock enable was low");

  // checks in the link domain
  property p_shift_step;
    @(posedge link_clk) disable iff (link_rst)
      shift_en && !link_clr |=>
        shift_reg == {$past(shift_reg[NUM_SWITCH-2:0]), $past(serial_din)};
  endproperty

  a_shift_one_bit: assert property (p_shift_step) // [RULE1]
    else $error("shift register did not take the serial input bit");

  a_shift_hold_idle: assert property ( // [RULE6]
    @(posedge link_clk) disable iff (link_rst)
      !shift_en && !link_clr |=> $stable(shift_reg) && $stable(serial_dout))
    else $error("shift register moved while shifting was inactive");

  a_dout_last_stage: assert property ( // [RULE5]
    @(posedge link_clk) disable iff (link_rst)
      shift_en && !link_clr |=> serial_dout == $past(shift_reg[NUM_SWITCH-1]))
    else $error("serial output is not the bit leaving the last stage");

  a_link_clear: assert property ( // [RULE4]
    @(posedge link_clk) disable iff (link_rst)
      link_clr |=> (shift_reg == '0) && !serial_dout)
    else $error("master clear did not empty the shift register");

  a_toggle_on_shift: assert property (
    @(posedge link_clk) disable iff (link_rst)
      shift_prev && !shift_en |=> xfer_toggle != $past(xfer_toggle))
    else $error("end of a shift run not signalled to the system domain");
endmodule

// ===== verilog/ssa_pkg.sv
// constants shared by the serial switch array control block
// assumes the user imports the whole package into each module header
package ssa_pkg;
  localparam int          SSA_NUM_SWITCH  = 8;      // independently controlled switches
  localparam int          SSA_SYNC_DEPTH  = 2;      // flip-flops per synchroniser chain, one chain per bit
  localparam logic [7:0]  SSA_CLEAR_VALUE = 8'h00;  // every latch low, every switch open
  localparam logic        SSA_BIT_LOW     = 1'b0;   // reset level of single-bit state
endpackage

// ===== verilog/ssa_sync.sv
// multi-bit level synchroniser, one independent chain per bit
// assumes every input bit is a level that is stable for several destination clocks
`timescale 1ns/1ns
module ssa_sync
  import ssa_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // destination clock
  input  wire logic             clk,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage [SSA_SYNC_DEPTH];

  // no reset here: the chain also carries reset itself into the other domain
  always_ff @(posedge clk)
  begin
    stage[0] <= din;
    for (int i = 1; i < SSA_SYNC_DEPTH; i++)
    begin
      stage[i] <= stage[i-1];
    end
  end

  // only the last stage is ever read outside the chain
  assign dout = stage[SSA_SYNC_DEPTH-1];
endmodule

// ===== tb/ssa_host_model.sv
// host controller model: link clock, shift enable, serial data
// assumes the bench calls its tasks and pops dout_q for the expected chained bits
`timescale 1ns/1ns
module ssa_host_model (
  // link towards the block
  output logic link_clk,
  output logic shift_en,
  output logic serial_din
);
  logic       run    = 1'b0;
  logic [7:0] exp_sr = 8'h00;
  logic       dout_q[$];
  // link clock stands still low between frames
  initial
  begin
    link_clk = 1'b0;
    #4;
    forever #15 link_clk = run ? ~link_clk : 1'b0;
  end
  initial shift_en = 1'b0;
  initial serial_din = 1'b0;
  // free edges with shifting off, needed around reset and clear
  task automatic idle(input int n);
    run = 1'b1;
    repeat (n) @(posedge link_clk);
    @(negedge link_clk) run = 1'b0;
  endtask
  // msb first, one bit per edge; enable held as a level for the frame
  task automatic send(input logic [7:0] w);
    run = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge link_clk);
      shift_en   = 1'b1;
      serial_din = w[i];
      dout_q.push_back(exp_sr[7]);
      exp_sr     = {exp_sr[6:0], w[i]};
    end
    @(negedge link_clk);
    shift_en   = 1'b0;
    serial_din = ~serial_din; // released line does not keep its last bit
    @(negedge link_clk) run = 1'b0;
  endtask
endmodule

// ===== tb/ssa_switch_ctrl_tb.sv
// self-checking bench for the switch array control block
// assumes loads answer three clk edges after the load pin rises
`timescale 1ns/1ns
module ssa_switch_ctrl_tb;
  import ssa_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       master_clear_n = 1'b1;
  logic       latch_load = 1'b0;
  logic       link_clk, shift_en, serial_din, serial_dout;
  logic [7:0] switch_on, held, w;
  int         cyc = 0;
  int         mismatches = 0;
  int         check_count = 0;
  int         due_q[$];
  logic [7:0] sw_q[$];

  ssa_switch_ctrl dut_u (.clk, .rst, .ce, .master_clear_n, .latch_load, .link_clk,
                         .shift_en, .serial_din, .serial_dout, .switch_on);
  ssa_host_model host_u (.link_clk, .shift_en, .serial_din);

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // expected switch pattern, due a fixed number of clk edges from now
  task automatic note_sw(input logic [7:0] v, input int d);
    due_q.push_back(cyc + d);
    sw_q.push_back(v);
  endtask
  // pulse load for three edges, the exact answer latency
  task automatic load(input logic [7:0] v);
    @(posedge clk) #2 latch_load = 1'b1;
    note_sw(v, 3);
    repeat (3) @(posedge clk);
    #2 latch_load = 1'b0;
  endtask

  // switch drive checked on its due cycle, after that edge has settled
  always @(negedge clk)
    while (due_q.size() > 0 && due_q[0] <= cyc)
    begin
      void'(due_q.pop_front());
      cmp("switch_on", sw_q.pop_front(), switch_on);
    end
  // chained bit checked after every shifting link edge
  always @(posedge link_clk)
    if (shift_en === 1'b1)
    begin
      #2;
      cmp("serial_dout", {7'h00, host_u.dout_q.pop_front()}, {7'h00, serial_dout});
    end

  initial
  begin
    void'($urandom(32'habec2d85));
    fork
      host_u.idle(10);
    join_none
    repeat (4) @(posedge clk);
    #2 rst = 1'b0;
    note_sw(SSA_CLEAR_VALUE, 0);
    wait fork;
    $display("test reset done");
    // all-on, all-off, then random patterns; mirror settles before load
    for (int i = 0; i < 6; i++)
    begin
      w = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      host_u.send(w);
      repeat (5) @(posedge clk);
      load(w);
    end
    $display("test load done");
    // shifting without load, then load refused while ce is low
    held = w;
    host_u.send(~w);
    repeat (5) @(posedge clk);
    note_sw(held, 1);
    @(posedge clk) #2 ce = 1'b0;
    latch_load = 1'b1;
    note_sw(held, 4);
    repeat (4) @(posedge clk);
    #2 latch_load = 1'b0;
    repeat (4) @(posedge clk);
    #2 ce = 1'b1;
    $display("test hold done");
    // master clear empties both registers; link must run to clear its side
    @(posedge clk) #2 master_clear_n = 1'b0;
    note_sw(SSA_CLEAR_VALUE, 3);
    host_u.idle(4);
    host_u.exp_sr = 8'h00;
    @(posedge clk) #2 master_clear_n = 1'b1;
    host_u.idle(4);
    host_u.send(8'h3c);
    repeat (5) @(posedge clk);
    load(8'h3c);
    repeat (3) @(posedge clk);
    $display("test clear done");
    close_out();
  end

  // watchdog far beyond the under two hundred clk cycles the tests need
  initial
  begin
    #1000000;
    mismatches++;
    close_out();
  end
endmodule
